// >>> logic/dss_pkg.sv
package dss_pkg;

  // register byte addresses
  localparam logic [15:0] DSS_LOCK_OFF   = 16'h8300;
  localparam logic [15:0] DSS_GCFG_OFF   = 16'h8304;
  localparam logic [15:0] DSS_TCFG_OFF   = 16'h8308;
  localparam logic [15:0] DSS_SCTL_OFF   = 16'h830C;
  localparam logic [15:0] DSS_FSTAT_OFF  = 16'h8310;

  // timing configuration, general configuration and status control field positions
  localparam int DSS_VIRQ_BIT   = 31;
  localparam int DSS_VINA_BIT   = 30;
  localparam int DSS_LINA_BIT   = 29;
  localparam int DSS_RSVD_BIT   = 28;
  localparam int DSS_DDC_BIT    = 27;
  localparam int DSS_TCFG_W     = 27;
  localparam int DSS_FLE_BIT    = 0;
  localparam int DSS_CLR_VIRQ   = 0;
  localparam int DSS_CLR_UNDR   = 1;

  // values after reset, and the unlock key
  localparam logic [DSS_TCFG_W-1:0] DSS_TCFG_RST = 27'h0000000;
  localparam logic                  DSS_FLE_RST  = 1'b0;
  localparam logic                  DSS_UNLK_RST = 1'b0;
  localparam logic [31:0]           DSS_UNLOCK_KEY = 32'h0000A5A5;

  // scan timing defaults, in pixel clocks and lines
  localparam logic [11:0] DSS_H_ACTIVE = 12'h280;
  localparam logic [11:0] DSS_H_TOTAL  = 12'h320;
  localparam logic [11:0] DSS_V_ACTIVE = 12'h1E0;
  localparam logic [11:0] DSS_V_TOTAL  = 12'h20D;

  // display fifo shape
  localparam int DSS_FIFO_W     = 64;
  localparam int DSS_FIFO_DEPTH = 8;

endpackage : dss_pkg

// >>> logic/dss_scan_gen.sv
`timescale 1ns/100ps
module dss_scan_gen #(
  parameter logic [11:0] H_ACTIVE = dss_pkg::DSS_H_ACTIVE,
  parameter logic [11:0] H_TOTAL  = dss_pkg::DSS_H_TOTAL,
  parameter logic [11:0] V_ACTIVE = dss_pkg::DSS_V_ACTIVE,
  parameter logic [11:0] V_TOTAL  = dss_pkg::DSS_V_TOTAL
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             line_inactive,
  output logic             vert_inactive,
  output logic             vblank_start,
  output logic [11:0]      line_count
);
  import dss_pkg::*;

  typedef struct packed {
    logic [11:0] h;
    logic [11:0] v;
    logic        hi;
    logic        vi;
    logic        vs;
  } dss_scan_t;

  dss_scan_t r;
  dss_scan_t n;

  always_comb begin
    n    = r;
    n.vs = 1'b0;
    if (r.h == H_TOTAL - 12'h001) begin
      n.h = 12'h000;
      if (r.v == V_TOTAL - 12'h001) begin
        n.v = 12'h000;
      end else begin
        n.v = r.v + 12'h001;
      end
      // one pulse as the first non-active line begins
      n.vs = (n.v == V_ACTIVE);
    end else begin
      n.h = r.h + 12'h001;
    end
    n.hi = (n.h >= H_ACTIVE);
    n.vi = (n.v >= V_ACTIVE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign line_inactive = r.hi;
  assign vert_inactive = r.vi;
  assign vblank_start  = r.vs;
  assign line_count    = r.v;

endmodule : dss_scan_gen

// >>> logic/dss_fifo.sv
`timescale 1ns/100ps
module dss_fifo #(
  parameter int W     = dss_pkg::DSS_FIFO_W,
  parameter int DEPTH = dss_pkg::DSS_FIFO_DEPTH
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     load_en,
  input  wire logic                     wr_valid,
  input  wire logic [W-1:0]             wr_data,
  output logic                          wr_ready,
  input  wire logic                     rd_req,
  output logic [W-1:0]                  rd_data,
  output logic                          rd_valid,
  output logic                          underrun,
  output logic [$clog2(DEPTH):0]        level
);
  import dss_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            rdat;
    logic                    rv;
    logic                    und;
  } dss_fifo_t;

  dss_fifo_t r;
  dss_fifo_t n;
  logic      do_wr;
  logic      do_rd;

  // no traffic at all while loading is disabled; contents are kept
  assign do_wr    = load_en & wr_valid & (r.cnt != DEPTH[AW:0]);
  assign do_rd    = load_en & rd_req & (r.cnt != '0);
  assign wr_ready = load_en & (r.cnt != DEPTH[AW:0]);

  always_comb begin
    n     = r;
    n.rv  = do_rd;
    n.und = load_en & rd_req & (r.cnt == '0);
    if (do_wr) begin
      n.mem[r.wp] = wr_data;
      n.wp        = r.wp + 1'b1;
    end
    if (do_rd) begin
      n.rdat = r.mem[r.rp];
      n.rp   = r.rp + 1'b1;
    end
    case ({do_wr, do_rd})
      2'b10:   n.cnt = r.cnt + 1'b1;
      2'b01:   n.cnt = r.cnt - 1'b1;
      default: n.cnt = r.cnt;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data  = r.rdat;
  assign rd_valid = r.rv;
  assign underrun = r.und;
  assign level    = r.cnt;

endmodule : dss_fifo

// >>> logic/dss_status_top.sv
`timescale 1ns/100ps
module dss_status_top #(
  parameter int          FIFO_W     = dss_pkg::DSS_FIFO_W,
  parameter int          FIFO_DEPTH = dss_pkg::DSS_FIFO_DEPTH,
  parameter logic [11:0] H_ACTIVE   = dss_pkg::DSS_H_ACTIVE,
  parameter logic [11:0] H_TOTAL    = dss_pkg::DSS_H_TOTAL,
  parameter logic [11:0] V_ACTIVE   = dss_pkg::DSS_V_ACTIVE,
  parameter logic [11:0] V_TOTAL    = dss_pkg::DSS_V_TOTAL
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [15:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ddc_input_pin,
  input  wire logic                          mem_valid,
  input  wire logic [FIFO_W-1:0]             mem_data,
  output logic                               mem_ready,
  input  wire logic                          pix_req,
  output logic [FIFO_W-1:0]                  pix_data,
  output logic                               pix_valid,
  output logic                               line_inactive,
  output logic                               vert_inactive
);
  import dss_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [31:0]           rdat;
    logic                  unlocked;
    logic                  fifo_load_enable;
    logic                  vert_irq_pending;
    logic                  underrun_seen;
    logic                  ddc_in_status;
    logic [DSS_TCFG_W-1:0] tcfg;
  } dss_regs_t;

  dss_regs_t   r;
  dss_regs_t   n;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic        li;
  logic        vi;
  logic        vb_start;
  logic [11:0] line_no;
  logic        underrun;
  logic [LW-1:0] level;
  logic [31:0] rd_word;

  // one decode serves both the error answer and the write enable
  function automatic logic addr_hit(input logic [15:0] a);
    addr_hit = (a == DSS_LOCK_OFF) || (a == DSS_GCFG_OFF) || (a == DSS_TCFG_OFF) ||
               (a == DSS_SCTL_OFF) || (a == DSS_FSTAT_OFF);
  endfunction : addr_hit

  function automatic logic is_reg(input logic [15:0] a, input logic [15:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  dss_scan_gen #(
    .H_ACTIVE (H_ACTIVE),
    .H_TOTAL  (H_TOTAL),
    .V_ACTIVE (V_ACTIVE),
    .V_TOTAL  (V_TOTAL)
  ) u_scan (
    .pclk          (pclk),
    .presetn       (presetn),
    .line_inactive (li),
    .vert_inactive (vi),
    .vblank_start  (vb_start),
    .line_count    (line_no)
  );

  dss_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .load_en  (r.fifo_load_enable),
    .wr_valid (mem_valid),
    .wr_data  (mem_data),
    .wr_ready (mem_ready),
    .rd_req   (pix_req),
    .rd_data  (pix_data),
    .rd_valid (pix_valid),
    .underrun (underrun),
    .level    (level)
  );

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite & addr_hit(paddr);

  // read word assembled from live state; sampled in the setup cycle
  always_comb begin
    rd_word = 32'h00000000;
    if (is_reg(paddr, DSS_LOCK_OFF)) begin
      rd_word[0] = r.unlocked;
    end else if (is_reg(paddr, DSS_GCFG_OFF)) begin
      rd_word[DSS_FLE_BIT] = r.fifo_load_enable;
    end else if (is_reg(paddr, DSS_TCFG_OFF)) begin
      rd_word[DSS_TCFG_W-1:0]  = r.tcfg;
      rd_word[DSS_VIRQ_BIT]    = r.vert_irq_pending;
      rd_word[DSS_VINA_BIT]    = vi;
      rd_word[DSS_LINA_BIT]    = li;
      rd_word[DSS_RSVD_BIT]    = 1'b0;
      rd_word[DSS_DDC_BIT]     = r.ddc_in_status;
    end else if (is_reg(paddr, DSS_SCTL_OFF)) begin
      rd_word[DSS_CLR_VIRQ] = r.vert_irq_pending;
      rd_word[DSS_CLR_UNDR] = r.underrun_seen;
    end else if (is_reg(paddr, DSS_FSTAT_OFF)) begin
      rd_word[LW-1:0]  = level;
      rd_word[27:16]   = line_no;
    end
  end

  always_comb begin
    n               = r;
    n.ddc_in_status = ddc_input_pin;
    if (setup_ph) begin
      n.rdat = rd_word;
    end
    if (wr_acc) begin
      if (is_reg(paddr, DSS_LOCK_OFF)) begin
        n.unlocked = (pwdata == DSS_UNLOCK_KEY);
      end
      if (is_reg(paddr, DSS_GCFG_OFF)) begin
        // panel power-down or crt blanking is left to software
        n.fifo_load_enable = pwdata[DSS_FLE_BIT];
      end
      if (is_reg(paddr, DSS_TCFG_OFF) && r.unlocked) begin
        // status bits above the stored field are read-only
        n.tcfg = pwdata[DSS_TCFG_W-1:0];
      end
      if (is_reg(paddr, DSS_SCTL_OFF)) begin
        if (pwdata[DSS_CLR_VIRQ]) begin
          n.vert_irq_pending = 1'b0;
        end
        if (pwdata[DSS_CLR_UNDR]) begin
          n.underrun_seen = 1'b0;
        end
      end
    end
    // sets come last so an event in the clear cycle survives
    if (vb_start) begin
      n.vert_irq_pending = 1'b1;
    end
    if (underrun) begin
      n.underrun_seen = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r                  <= '0;
      r.unlocked         <= DSS_UNLK_RST;
      r.fifo_load_enable <= DSS_FLE_RST;
      r.tcfg             <= DSS_TCFG_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata        = r.rdat;
  assign pready        = access_ph;
  assign pslverr       = access_ph & ~addr_hit(paddr);
  assign line_inactive = li;
  assign vert_inactive = vi;

endmodule : dss_status_top

// >>> test/dss_status_sva.sv
`timescale 1ns/100ps
module dss_status_sva
  import dss_pkg::*;
#(
  parameter logic [11:0] H_ACTIVE = DSS_H_ACTIVE,
  parameter logic [11:0] H_TOTAL  = DSS_H_TOTAL,
  parameter logic [11:0] V_ACTIVE = DSS_V_ACTIVE
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        ddc_input_pin,
  input wire logic        mem_ready,
  input wire logic        pix_req,
  input wire logic        pix_valid,
  input wire logic        line_inactive,
  input wire logic        vert_inactive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        fle_r;
  logic        lock_r;
  logic [26:0] tcfg_r;
  logic [31:0] vcnt_r;
  logic [15:0] lcnt_r;
  logic [1:0]  seen_r;
  wire         wr   = psel && penable && pwrite;
  wire         rd_t = psel && penable && !pwrite && paddr == DSS_TCFG_OFF;
  // shadow fed only from the bus, so a stuck register inside shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fle_r  <= DSS_FLE_RST;
      lock_r <= 1'b1;
      tcfg_r <= DSS_TCFG_RST;
      vcnt_r <= 32'h00000000;
      lcnt_r <= 16'h0000;
      seen_r <= 2'h0;
    end else begin
      if (wr && paddr == DSS_GCFG_OFF) fle_r <= pwdata[DSS_FLE_BIT];
      if (wr && paddr == DSS_LOCK_OFF) lock_r <= pwdata != DSS_UNLOCK_KEY;
      if (wr && paddr == DSS_TCFG_OFF && !lock_r) tcfg_r <= pwdata[DSS_TCFG_W-1:0];
      vcnt_r <= vert_inactive ? 32'h00000000 : vcnt_r + 32'h00000001;
      lcnt_r <= line_inactive ? 16'h0000 : lcnt_r + 16'h0001;
      seen_r <= seen_r | {vert_inactive, line_inactive};
    end
  end
  mem_gate_a: assert property (!fle_r |-> !mem_ready)
    else $error("fill accepted while load off");
  pix_gate_a: assert property (!fle_r && pix_req |=> !pix_valid)
    else $error("fifo read while load off");
  tcfg_keep_a: assert property (rd_t |-> prdata[26:0] == tcfg_r)
    else $error("timing field wrong");
  rsvd_zero_a: assert property (rd_t |-> !prdata[DSS_RSVD_BIT])
    else $error("reserved bit set");
  scan_bits_a: assert property (rd_t |-> prdata[30:29] == $past({vert_inactive, line_inactive}))
    else $error("scan bits differ from scan outputs");
  ddc_level_a: assert property (rd_t |-> prdata[DSS_DDC_BIT] == $past(ddc_input_pin, 2))
    else $error("ddc bit differs from pin");
  line_span_a: assert property ($rose(line_inactive) && seen_r[0] |-> lcnt_r == H_ACTIVE)
    else $error("active line part wrong length");
  vert_span_a: assert property ($rose(vert_inactive) && seen_r[1] |-> vcnt_r == V_ACTIVE * H_TOTAL)
    else $error("active frame part wrong length");
  cover property (rd_t);
  cover property (mem_ready && fle_r);
  cover property (pix_valid);
endmodule : dss_status_sva
bind dss_status_top dss_status_sva #(.H_ACTIVE(H_ACTIVE), .H_TOTAL(H_TOTAL), .V_ACTIVE(V_ACTIVE))
  dss_status_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .ddc_input_pin,
  .mem_ready, .pix_req, .pix_valid, .line_inactive, .vert_inactive);

// >>> test/dss_panel_model.sv
`timescale 1ns/100ps
module dss_panel_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic powered,
  input  wire logic slow,
  output logic      pix_req
);
  logic ph_r;
  // a slow panel asks every other cycle, so the fifo backs up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
    end
  end
  assign pix_req = powered && (!slow || ph_r);
endmodule : dss_panel_model

// >>> test/dss_status_top_tb.sv
`timescale 1ns/100ps
module dss_status_top_tb;
  import dss_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, mem_ready, pix_req, pix_valid, line_inactive, vert_inactive;
  logic        ddc_input_pin = 1'b0;
  logic        mem_valid = 1'b0;
  logic        pwr = 1'b0;
  logic        slow = 1'b0;
  logic [63:0] mem_data = 64'h0, pix_data;
  logic [26:0] t;
  logic [63:0] q[$];
  int          n_mismatch = 0, checks = 0, cyc = 0, seed = 32'h90ef;
  always #10 pclk = ~pclk;
  dss_status_top #(.H_ACTIVE(12'h005), .H_TOTAL(12'h008), .V_ACTIVE(12'h004), .V_TOTAL(12'h006))
    dss_status_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ddc_input_pin, .mem_valid, .mem_data, .mem_ready, .pix_req, .pix_data, .pix_valid, .line_inactive,
    .vert_inactive);
  dss_panel_model dss_panel_model_i (.pclk, .presetn, .powered(pwr), .slow, .pix_req);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic push(input logic [63:0] d);
    @(posedge pclk);
    mem_valid <= 1'b1;
    mem_data <= d;
    do @(posedge pclk); while (mem_ready !== 1'b1);
    q.push_back(d);
    mem_valid <= 1'b0;
  endtask : push
  always @(posedge pclk) begin
    if (pix_valid === 1'b1) chk(pix_data, q.size() ? q.pop_front() : 64'hX);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk({rd[28], rd[19:0]}, 64'h0);
    t = 27'($random(seed));
    apb(1'b1, DSS_TCFG_OFF, {5'h1F, t});
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk(rd[26:0], 64'h0);
    apb(1'b1, DSS_LOCK_OFF, DSS_UNLOCK_KEY);
    apb(1'b1, DSS_TCFG_OFF, {5'h1F, t});
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk({rd[28], rd[26:0]}, {1'b0, t});
    apb(1'b0, 16'h8318, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("register test done");
    pwr <= 1'b1;
    mem_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(mem_ready, 1'b0);
    mem_valid <= 1'b0;
    apb(1'b1, DSS_GCFG_OFF, 32'h1);
    for (int i = 0; i < 12; i++) begin
      slow <= i[2];
      push({$random(seed), $random(seed)});
    end
    repeat (2) @(posedge pclk);
    pwr <= 1'b0;
    push({$random(seed), $random(seed)});
    apb(1'b1, DSS_GCFG_OFF, 32'h0);
    pwr <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(q.size(), 64'h1);
    apb(1'b1, DSS_GCFG_OFF, 32'h1);
    repeat (10) @(posedge pclk);
    chk(q.size(), 64'h0);
    $display("fifo test done");
    for (int i = 0; i < 4; i++) begin
      ddc_input_pin <= 1'($random(seed));
      repeat (3) @(posedge pclk);
      apb(1'b0, DSS_TCFG_OFF, 32'h0);
      chk(rd[DSS_DDC_BIT], ddc_input_pin);
    end
    do @(posedge pclk); while (vert_inactive !== 1'b1);
    apb(1'b1, DSS_TCFG_OFF, {5'h00, t});
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk(rd[DSS_VIRQ_BIT], 1'b1);
    apb(1'b0, DSS_SCTL_OFF, 32'h0);
    chk(rd[DSS_CLR_VIRQ], 1'b1);
    apb(1'b1, DSS_SCTL_OFF, 32'h1);
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk(rd[DSS_VIRQ_BIT], 1'b0);
    apb(1'b1, DSS_LOCK_OFF, 32'h0);
    apb(1'b1, DSS_TCFG_OFF, 32'h0);
    apb(1'b0, DSS_TCFG_OFF, 32'h0);
    chk(rd[26:0], t);
    $display("scan test done");
    end_of_test;
  end
endmodule : dss_status_top_tb
